// File: src/acquisition_timing_config.sv
// Purpose: Acquisition configuration, settling delay and self-test alerts
// Assumes: One clock, synchronous reset, APB register slave
// Notes:   Measurement datapath and sequencer sit outside this block
//
// Contract
// RQ1 - Settling lasts the 10-bit count times 6 us, from 0 to 6.138 ms.
// RQ2 - The settling interval opens every requested scan before measuring.
// RQ3 - The pump is refreshed while settling runs with no measurement active.
// RQ4 - In automatic bias mode the bias pin stays off until acquisition.
// RQ5 - With stuck check on, ADC scans end with zero- then full-scale tests.
// RQ6 - Zero-scale result not 000 or full-scale not FFF raises its alert.
// RQ7 - Calibration is applied to scan results only while its bit is set.
// RQ8 - With accuracy check on, comparator scans end with a limit test.
// RQ9 - An unexpected comparator test raises the high or low alert.
// RQ10 - Frequency field 00 is free-running, 01 is 1.60 kHz, 1x is 1.92 kHz.
// RQ11 - The selected rate applies only when oversampling count is not 000.
// RQ12 - With 00 the rate is the maximum set by the enabled features.
// RQ13 - Bias mode 0x closes during acquisition, 10 open, 11 closed.
// RQ14 - Settling count and all fields are sampled at each scan start.
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
module acquisition_timing_config
  import acq_cfg_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // APB slave
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  input  wire logic [3:0]        pstrb_i,
  output logic [31:0]            prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  // Sequencer side
  input  wire logic              scan_req_i,
  input  wire logic [2:0]        scan_type_sel_i,
  input  wire logic [2:0]        oversample_count_sel_i,
  input  wire logic              meas_active_i,
  input  wire logic              seq_done_i,
  output logic                   settle_busy_o,
  output logic                   measure_go_o,
  output logic                   high_voltage_pump_o,
  output logic                   bias_output_pin_o,
  output logic                   adc_cal_apply_o,
  output logic [1:0]             rate_sel_o,
  // Self-test path
  output logic                   force_zero_o,
  output logic                   force_full_o,
  output logic                   comp_test_o,
  input  wire logic              test_valid_i,
  input  wire logic [11:0]       adc_result_i,
  input  wire logic              comp_above_high_i,
  input  wire logic              comp_below_low_i,
  output logic                   test_done_o,
  output logic                   irq_o
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETTLE,
    ST_MEASURE,
    ST_TEST_ZS,
    ST_TEST_FS,
    ST_TEST_COMP
  } seq_state_e;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [SETTLE_W-1:0] aux_settle_count;
  logic [15:0]         acquisition_config;
  logic [ALERT_W-1:0]  alert_status;
  logic [ALERT_W-1:0]  alert_mask;

  // Snapshot taken at scan start
  logic [15:0]         cfg_snap;
  logic [2:0]          type_snap;
  logic [2:0]          ovs_snap;

  seq_state_e          state;
  seq_state_e          next_state;
  logic                timer_busy;
  logic                timer_done;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire [7:0] word_idx = paddr_i[ADDR_LSB +: 8];
  wire       access   = psel_i && penable_i;
  wire       wr_en    = access && pwrite_i;
  wire       hit_aux  = (word_idx == IDX_AUX_SETTLE_TIME);
  wire       hit_acq  = (word_idx == IDX_ACQUISITION_CONFIG);
  wire       hit_stat = (word_idx == IDX_ALERT_STATUS);
  wire       hit_mask = (word_idx == IDX_ALERT_MASK);
  wire       hit_scan = (word_idx == IDX_SCAN_STATUS);
  wire       mapped   = hit_aux || hit_acq || hit_stat || hit_mask
                        || hit_scan;
  wire       wr_lo    = wr_en && pstrb_i[0];
  wire       wr_hi    = wr_en && pstrb_i[1];

  wire [15:0] wdata16 = pwdata_i[15:0];
  wire [15:0] next_acq = {wr_hi ? wdata16[15:8] : acquisition_config[15:8],
                          wr_lo ? wdata16[7:0] : acquisition_config[7:0]}
                         & ACQ_CFG_MASK;
  wire [SETTLE_W-1:0] next_aux =
    {wr_hi ? wdata16[9:8] : aux_settle_count[9:8],
     wr_lo ? wdata16[7:0] : aux_settle_count[7:0]};

  wire [31:0] rd_aux  = {22'h0, aux_settle_count};
  wire [31:0] rd_acq  = {16'h0000, acquisition_config};
  wire [31:0] rd_stat = {28'h000_0000, alert_status};
  wire [31:0] rd_mask = {28'h000_0000, alert_mask};
  wire [31:0] rd_scan = {29'h0, timer_busy,
                         (state != ST_IDLE), (state >= ST_TEST_ZS)};
  wire [31:0] rd_mux  = hit_aux  ? rd_aux  :
                        hit_acq  ? rd_acq  :
                        hit_stat ? rd_stat :
                        hit_mask ? rd_mask :
                        hit_scan ? rd_scan : 32'h0000_0000;

  assign pready_o  = 1'b1;
  assign pslverr_o = access && !mapped;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      prdata_o <= rd_mux;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aux_settle_count   <= SETTLE_RESET;
      acquisition_config <= ACQ_CFG_RESET;
      alert_mask         <= '0;
    end else begin
      if (hit_aux) begin
        aux_settle_count <= next_aux;
      end
      if (hit_acq) begin
        acquisition_config <= next_acq;
      end
      if (hit_mask && wr_lo) begin
        alert_mask <= wdata16[ALERT_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Scan sequence
  // ----------------------------------------------------------------
  wire is_adc_scan  = (type_snap != SCAN_COMP_ONLY); // RQ5
  wire is_comp_scan = (type_snap == SCAN_ADC_COMP)
                      || (type_snap == SCAN_COMP_ONLY); // RQ8
  wire stuck_on     = cfg_snap[BIT_STUCK_EN] && is_adc_scan;
  wire comp_on      = cfg_snap[BIT_COMPACC_EN] && is_comp_scan;
  wire start_scan   = (state == ST_IDLE) && scan_req_i;

  settle_timer u_settle_timer (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .load_i  (start_scan), // RQ2
    .count_i (aux_settle_count), // RQ1
    .busy_o  (timer_busy),
    .done_o  (timer_done)
  );

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE:    if (scan_req_i) next_state = ST_SETTLE; // RQ2
      ST_SETTLE:  if (timer_done) next_state = ST_MEASURE;
      ST_MEASURE: begin
        if (seq_done_i) begin
          next_state = stuck_on ? ST_TEST_ZS : // RQ5
                       comp_on  ? ST_TEST_COMP : ST_IDLE; // RQ8
        end
      end
      ST_TEST_ZS: if (test_valid_i) next_state = ST_TEST_FS;
      ST_TEST_FS: begin
        if (test_valid_i) next_state = comp_on ? ST_TEST_COMP : ST_IDLE;
      end
      ST_TEST_COMP: if (test_valid_i) next_state = ST_IDLE;
      default:    next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_snap  <= ACQ_CFG_RESET;
      type_snap <= '0;
      ovs_snap  <= OVS_OFF;
    end else if (start_scan) begin
      cfg_snap  <= acquisition_config; // RQ14
      type_snap <= scan_type_sel_i;
      ovs_snap  <= oversample_count_sel_i;
    end
  end

  // ----------------------------------------------------------------
  // Alerts: set wins over write-one-to-clear
  // ----------------------------------------------------------------
  wire zs_bad = (state == ST_TEST_ZS) && test_valid_i
                && (adc_result_i != ADC_ZERO_SCALE); // RQ6
  wire fs_bad = (state == ST_TEST_FS) && test_valid_i
                && (adc_result_i != ADC_FULL_SCALE); // RQ6
  wire c_test = (state == ST_TEST_COMP) && test_valid_i;
  wire [ALERT_W-1:0] alert_set;
  assign alert_set[AL_ZS]  = zs_bad;
  assign alert_set[AL_FS]  = fs_bad;
  assign alert_set[AL_CHI] = c_test && comp_above_high_i; // RQ9
  assign alert_set[AL_CLO] = c_test && comp_below_low_i; // RQ9
  wire [ALERT_W-1:0] alert_clr = (hit_stat && wr_lo) ?
                                 wdata16[ALERT_W-1:0] : '0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alert_status <= '0;
    end else begin
      alert_status <= (alert_status & ~alert_clr) | alert_set;
    end
  end

  // A set mask bit hides its alert from the interrupt
  assign irq_o = |(alert_status & ~alert_mask);

  // ----------------------------------------------------------------
  // Outputs to the measurement engine
  // ----------------------------------------------------------------
  wire [1:0] bias_mode = cfg_snap[BIAS_HI:BIAS_LO];
  wire [1:0] oversample_freq_sel      = cfg_snap[OVERSAMPLE_FREQ_SEL_HI:OVERSAMPLE_FREQ_SEL_LO];
  wire       acq_on    = (state != ST_IDLE);
  wire       ovs_on    = (ovs_snap != OVS_OFF); // RQ11
  wire [1:0] rate_pick = !oversample_freq_sel[1] && !oversample_freq_sel[0] ? RATE_MAX : // RQ12
                         !oversample_freq_sel[1] ? RATE_1600 : RATE_1920; // RQ10

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bias_output_pin_o   <= 1'b0;
      high_voltage_pump_o <= 1'b0;
      rate_sel_o          <= RATE_MAX;
      adc_cal_apply_o     <= 1'b0;
    end else begin
      bias_output_pin_o   <= bias_mode[1] ? bias_mode[0] : acq_on; // RQ13 RQ4
      high_voltage_pump_o <= (state == ST_SETTLE) && !meas_active_i; // RQ3
      rate_sel_o          <= ovs_on ? rate_pick : RATE_MAX; // RQ11
      adc_cal_apply_o     <= cfg_snap[BIT_CAL_EN]; // RQ7
    end
  end

  assign settle_busy_o = (state == ST_SETTLE);
  assign measure_go_o  = (state == ST_MEASURE);
  assign force_zero_o  = (state == ST_TEST_ZS);
  assign force_full_o  = (state == ST_TEST_FS);
  assign comp_test_o   = (state == ST_TEST_COMP);
  assign test_done_o   = (state != ST_IDLE) && (next_state == ST_IDLE);

endmodule : acquisition_timing_config

// File: common/acq_cfg_pkg.sv
// Purpose: Constants and types shared by the acquisition timing block
// Assumes: 40 MHz system clock, APB register access
// Notes:   Register offsets are word indices; byte address is four times
package acq_cfg_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_AUX_SETTLE_TIME = 8'h61;
  localparam logic [7:0] IDX_ACQUISITION_CONFIG = 8'h62;
  localparam logic [7:0] IDX_ALERT_STATUS = 8'h70;
  localparam logic [7:0] IDX_ALERT_MASK = 8'h71;
  localparam logic [7:0] IDX_SCAN_STATUS = 8'h72;
  localparam int unsigned ADDR_LSB = 2;
  localparam int unsigned ADDR_W = 10;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int unsigned SETTLE_W = 10;
  localparam int unsigned BIT_STUCK_EN = 15;
  localparam int unsigned BIT_CAL_EN = 14;
  localparam int unsigned BIT_COMPACC_EN = 13;
  localparam int unsigned OVERSAMPLE_FREQ_SEL_HI = 12;
  localparam int unsigned OVERSAMPLE_FREQ_SEL_LO = 11;
  localparam int unsigned BIAS_HI = 10;
  localparam int unsigned BIAS_LO = 9;
  localparam logic [15:0] ACQ_CFG_MASK = 16'hFE00;
  localparam logic [15:0] ACQ_CFG_RESET = 16'h0000;
  localparam logic [9:0] SETTLE_RESET = 10'h000;

  // Alert bits in the status and mask registers
  localparam int unsigned ALERT_W = 4;
  localparam int unsigned AL_ZS = 0;
  localparam int unsigned AL_FS = 1;
  localparam int unsigned AL_CHI = 2;
  localparam int unsigned AL_CLO = 3;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] SCAN_COMP_ONLY = 3'h2;
  localparam logic [2:0] SCAN_ADC_COMP = 3'h1;
  localparam logic [2:0] OVS_OFF = 3'h0;
  localparam logic [11:0] ADC_ZERO_SCALE = 12'h000;
  localparam logic [11:0] ADC_FULL_SCALE = 12'hFFF;

  typedef enum logic [1:0] {
    RATE_MAX,
    RATE_1600,
    RATE_1920
  } rate_sel_e;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned SETTLE_STEP_US = 6;
  localparam int unsigned STEP_CYCLES = SETTLE_STEP_US * (CLK_HZ / 1_000_000);
  localparam int unsigned STEP_CNT_W = $clog2(STEP_CYCLES);
  localparam logic [STEP_CNT_W-1:0] STEP_LAST = STEP_CNT_W'(STEP_CYCLES - 1);

endpackage : acq_cfg_pkg

// File: src/settle_timer.sv
// Purpose: Settling delay counter in 6 us steps
// Assumes: Count loaded once per scan
// Notes:   A count of zero finishes in the cycle after the load
`timescale 1ns/1ps
module settle_timer
  import acq_cfg_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                load_i,
  input  wire logic [SETTLE_W-1:0] count_i,
  output logic                     busy_o,
  output logic                     done_o
);

  logic [STEP_CNT_W-1:0] step_cnt;
  logic [SETTLE_W-1:0]   steps_left;
  logic                  running;

  wire step_tick = running && (step_cnt == STEP_LAST);
  wire last_step = step_tick && (steps_left == SETTLE_W'(1));
  wire zero_done = running && (steps_left == '0);

  always_ff @(posedge clk_i) begin
    if (rst_i || load_i || !running || step_tick) begin
      step_cnt <= '0;
    end else begin
      step_cnt <= step_cnt + STEP_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      running    <= 1'b0;
      steps_left <= '0;
      done_o     <= 1'b0;
    end else if (load_i) begin
      running    <= 1'b1;
      steps_left <= count_i;
      done_o     <= 1'b0;
    end else begin
      done_o <= last_step || zero_done;
      if (last_step || zero_done) begin
        running <= 1'b0;
      end
      if (step_tick) begin
        steps_left <= steps_left - SETTLE_W'(1);
      end
    end
  end

  assign busy_o = running;

endmodule : settle_timer

// File: testbench/acq_timing_chk.sv
// Purpose: Port-level checker for the acquisition timing block
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to every instance of the block
`timescale 1ns/1ps
module acq_timing_chk (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       scan_req_i,
  input wire logic       meas_active_i,
  input wire logic       seq_done_i,
  input wire logic       test_valid_i,
  input wire logic       settle_busy_o,
  input wire logic       measure_go_o,
  input wire logic       high_voltage_pump_o,
  input wire logic [1:0] rate_sel_o,
  input wire logic       force_zero_o,
  input wire logic       force_full_o,
  input wire logic       comp_test_o,
  input wire logic       test_done_o
);
  wire idle = !(settle_busy_o || measure_go_o || force_zero_o ||
                force_full_o || comp_test_o);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  scan_start_a: assert property (
    idle && scan_req_i |=> settle_busy_o) else $error("scan not started");
  settle_first_a: assert property (
    $rose(measure_go_o) |-> $past(settle_busy_o))
    else $error("measure without settling");
  pump_on_a: assert property (
    settle_busy_o && !meas_active_i |=> high_voltage_pump_o)
    else $error("pump idle during settling");
  pump_off_a: assert property (
    !settle_busy_o || meas_active_i |=> !high_voltage_pump_o)
    else $error("pump refresh out of place");
  measure_hold_a: assert property (
    measure_go_o && !seq_done_i |=> measure_go_o)
    else $error("measure dropped early");
  zero_full_a: assert property (
    force_zero_o && test_valid_i |=> force_full_o)
    else $error("full-scale step missing");
  full_order_a: assert property (
    $rose(force_full_o) |-> $past(force_zero_o))
    else $error("full-scale before zero-scale");
  comp_entry_a: assert property (
    $rose(comp_test_o) |-> $past(measure_go_o) || $past(force_full_o))
    else $error("comparator test out of order");
  rate_code_a: assert property (
    rate_sel_o != 2'b11) else $error("bad rate code");
  done_idle_a: assert property (
    test_done_o |=> idle) else $error("not idle after done");
  one_state_a: assert property (
    $onehot0({settle_busy_o, measure_go_o, force_zero_o, force_full_o,
              comp_test_o})) else $error("two phases at once");
  cover property ($fell(settle_busy_o));
  cover property (force_full_o && test_valid_i);
  cover property (comp_test_o && test_valid_i);
endmodule : acq_timing_chk

bind acquisition_timing_config acq_timing_chk u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .scan_req_i(scan_req_i),
  .meas_active_i(meas_active_i), .seq_done_i(seq_done_i),
  .test_valid_i(test_valid_i), .settle_busy_o(settle_busy_o),
  .measure_go_o(measure_go_o), .high_voltage_pump_o(high_voltage_pump_o),
  .rate_sel_o(rate_sel_o), .force_zero_o(force_zero_o),
  .force_full_o(force_full_o), .comp_test_o(comp_test_o),
  .test_done_o(test_done_o));

// File: testbench/acquisition_timing_config_test.sv
// Purpose: Self-checking bench for the acquisition timing block
// Assumes: 40 MHz clock, APB master driven at rising edges
// Notes:   A set mask bit hides its alert from the interrupt
`timescale 1ns/1ps
module acquisition_timing_config_test
  import acq_cfg_pkg::*;
;
  logic        clk_i = 0, rst_i = 1, psel = 0, penable = 0, pwrite = 0;
  logic [9:0]  paddr = '0;
  logic [31:0] pwdata = '0, rdata, prdata;
  logic [3:0]  pstrb = '0;
  logic        req = 0, meas = 0, sdone = 0, tvalid = 0, hi = 0, lo = 0;
  logic        pready, pslverr, err, busy, go, pump, bias, cal;
  logic        fz, ff, ct, tdone, irq;
  logic [2:0]  stype = '0, ovs = '0;
  logic [11:0] res = '0;
  logic [1:0]  rate;
  int          mismatches = 0, cmp_count = 0;
  wire  [5:0]  stat = {~|{busy, go, fz, ff, ct}, ct, ff, fz, go, busy};

  initial forever #12.5 clk_i = ~clk_i;

  acquisition_timing_config dut (
    .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .scan_req_i(req), .scan_type_sel_i(stype),
    .oversample_count_sel_i(ovs), .meas_active_i(meas),
    .seq_done_i(sdone), .settle_busy_o(busy), .measure_go_o(go),
    .high_voltage_pump_o(pump), .bias_output_pin_o(bias),
    .adc_cal_apply_o(cal), .rate_sel_o(rate), .force_zero_o(fz),
    .force_full_o(ff), .comp_test_o(ct), .test_valid_i(tvalid),
    .adc_result_i(res), .comp_above_high_i(hi), .comp_below_low_i(lo),
    .test_done_o(tdone), .irq_o(irq));

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic tally_and_finish;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic hang;
    mismatches++;
    $display("unexpected wait: expected progress, seen timeout");
    tally_and_finish();
  endtask : hang

  task automatic chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] i,
                     input logic [31:0] d);
    int n;
    @(posedge clk_i);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= d;
    pstrb <= 4'hf;
    @(posedge clk_i);
    penable <= 1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) hang();
    rdata = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb

  task automatic rd(input logic [7:0] i, input string nm,
                    input logic [31:0] e);
    apb(0, i, '0);
    chk(nm, e, rdata);
  endtask : rd

  task automatic await(input int s);
    int n;
    for (n = 0; n < 2000 && stat[s] !== 1'b1; n++) @(posedge clk_i);
    if (n >= 2000) hang();
  endtask : await

  task automatic stage(input int s, input logic [11:0] r,
                       input logic h, l);
    await(s);
    tvalid <= 1;
    res <= r;
    hi <= h;
    lo <= l;
    @(posedge clk_i);
    tvalid <= 0;
  endtask : stage

  // Runs one scan up to its measure phase, timing the settling
  task automatic scan(input logic [2:0] t, o, input int len,
                      input logic pb, bb);
    int n;
    n = 0;
    stype <= t;
    ovs <= o;
    req <= 1;
    @(posedge clk_i);
    req <= 0;
    for (int k = 0; k < 2000 && !(n > 0 && busy !== 1'b1); k++) begin
      @(posedge clk_i);
      if (busy === 1'b1) n++;
      if (n == 3 && busy === 1'b1) begin
        chk("pump", pb, pump);
        chk("bias", bb, bias);
      end
    end
    if (n == 0 || busy === 1'b1) hang();
    if (len >= 0) chk("settle", len, n);
    chk("measure", 1, go);
  endtask : scan

  task automatic done(input int nxt);
    sdone <= 1;
    @(posedge clk_i);
    sdone <= 0;
    @(posedge clk_i);
    chk("next phase", 1, stat[nxt]);
  endtask : done

  // ------------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    rd(IDX_AUX_SETTLE_TIME, "aux", 0);
    rd(IDX_ACQUISITION_CONFIG, "acq", 0);
    rd(IDX_ALERT_MASK, "mask", 0);
    rd(8'h00, "unmapped", 0);
    chk("pslverr", 1, err);
    apb(1, IDX_AUX_SETTLE_TIME, 32'h0000_ffff);
    rd(IDX_AUX_SETTLE_TIME, "aux", 32'h0000_03ff);
    apb(1, IDX_ACQUISITION_CONFIG, 32'h0000_ffff);
    rd(IDX_ACQUISITION_CONFIG, "acq", 32'h0000_fe00);
    apb(1, IDX_AUX_SETTLE_TIME, 32'h0000_0001);
    apb(1, IDX_ACQUISITION_CONFIG, 32'h0000_a800);
    scan(3'h1, 3'h1, 241, 1, 1);
    apb(1, IDX_ACQUISITION_CONFIG, 32'h0000_f600);
    @(posedge clk_i);
    chk("rate", 1, rate);
    chk("cal", 0, cal);
    rd(IDX_SCAN_STATUS, "scan", 32'h0000_0002);
    done(2);
    stage(2, 12'h001, 0, 0);
    stage(3, 12'hfff, 0, 0);
    stage(4, 12'h000, 1, 0);
    await(5);
    rd(IDX_ALERT_STATUS, "status", 32'h0000_0005);
    chk("irq", 1, irq);
    apb(1, IDX_ALERT_MASK, 32'h0000_000f);
    @(posedge clk_i);
    chk("irq", 0, irq);
    apb(1, IDX_ALERT_STATUS, 32'h0000_0005);
    rd(IDX_ALERT_STATUS, "status", 0);
    apb(1, IDX_ALERT_MASK, 0);
    meas <= 1;
    scan(3'h2, 3'h0, 241, 0, 1);
    meas <= 0;
    chk("rate", 0, rate);
    chk("cal", 1, cal);
    done(4);
    stage(4, 12'h000, 0, 1);
    await(5);
    rd(IDX_ALERT_STATUS, "status", 32'h0000_0008);
    apb(1, IDX_ALERT_STATUS, 32'h0000_0008);
    apb(1, IDX_AUX_SETTLE_TIME, 32'h0000_0002);
    apb(1, IDX_ACQUISITION_CONFIG, 32'h0000_9c00);
    scan(3'h0, 3'h3, 481, 1, 0);
    chk("rate", 2, rate);
    done(2);
    stage(2, 12'h000, 0, 0);
    stage(3, 12'hfff, 0, 0);
    await(5);
    rd(IDX_ALERT_STATUS, "status", 0);
    apb(1, IDX_AUX_SETTLE_TIME, 0);
    apb(1, IDX_ACQUISITION_CONFIG, 32'h0000_0200);
    scan(3'h2, 3'h1, -1, 0, 0);
    chk("rate", 0, rate);
    chk("bias", 1, bias);
    done(5);
    tally_and_finish();
  end
endmodule : acquisition_timing_config_test
